// >>> hw/msirq_pkg.sv
`default_nettype none
package msirq_pkg;
    localparam int MSIRQ_W = 24;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [7:0] MSIRQ_IDX_FLAGS = 8'h0f;
    localparam logic [7:0] MSIRQ_IDX_ENABLE = 8'h1a;
    localparam logic [7:0] MSIRQ_IDX_TEMP = 8'h1b;
    localparam logic [7:0] MSIRQ_IDX_ACTIVE_ENERGY_PULSE_VALUE = 8'h1d;
    localparam logic [7:0] MSIRQ_IDX_APPARENT_ENERGY_PULSE_VALUE = 8'h1e;
    localparam logic [7:0] MSIRQ_IDX_REACTIVE_ENERGY_PULSE_VALUE = 8'h1f;
    localparam logic [7:0] MSIRQ_IDX_TSCALE = 8'h20;
    localparam logic [7:0] MSIRQ_IDX_TBIAS = 8'h21;
    localparam logic [23:0] MSIRQ_FLAGS_RST = 24'h000001;
    localparam logic [23:0] MSIRQ_ENABLE_RST = 24'h000000;
    // Gain is unsigned 2.22, so one is 0x400000
    localparam logic [23:0] MSIRQ_TSCALE_RST = 24'h400000;
    localparam logic [23:0] MSIRQ_TBIAS_RST = 24'h000000;
    localparam int MSIRQ_TSCALE_FRAC = 22;
    localparam int B_LOWRATE = 23;
    localparam int B_CUR_B_SAMP = 22;
    localparam int B_VOLT_B_SAMP = 21;
    localparam int B_SAMPLE_RDY = 20;
    localparam int B_CUR_B_RMS = 19;
    localparam int B_VOLT_B_RMS = 18;
    localparam int B_CUR_A_SAMP = 17;
    localparam int B_VOLT_A_SAMP = 16;
    localparam int B_ENERGY_B = 15;
    localparam int B_CUR_A_RMS = 14;
    localparam int B_VOLT_A_RMS = 13;
    localparam int B_ENERGY_A = 12;
    localparam int B_CUR_A_FAULT = 11;
    localparam int B_VOLT_A_DIP = 10;
    localparam int B_CUR_B_FAULT = 9;
    localparam int B_VOLT_B_DIP = 8;
    localparam int B_TEMP_UPD = 7;
    localparam int B_VOLT_B_OSC = 6;
    localparam int B_CUR_B_OSC = 5;
    localparam int B_VOLT_A_OSC = 4;
    localparam int B_CUR_A_OSC = 3;
    localparam int B_LOW_SUPPLY = 2;
    localparam int B_FREQ_UPD = 1;
    localparam int B_BAD_CMD_N = 0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } msirq_apb_req_t;

    typedef struct packed {
        logic [23:0] flags;
        logic [23:0] enable;
        logic [23:0] temp;
        logic [23:0] tscale;
        logic [23:0] tbias;
        logic [23:0] active_energy_pulse_value;
        logic [23:0] apparent_energy_pulse_value;
        logic [23:0] reactive_energy_pulse_value;
        logic [23:0] ev_s1;
        logic [23:0] ev_s2;
        logic [1:0] ls_s1;
        logic [1:0] ls_s2;
        logic ls_latched;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } msirq_state_t;
endpackage : msirq_pkg
`default_nettype wire

// >>> hw/msirq_top.sv
// Decided for this implementation: the APB slave port.
`default_nettype none
module msirq_top
    import msirq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Event level inputs, one per flag bit except bit 2, which is unused (low supply comes from the supply pins); bit 0 is the bad-command condition (high = bad)
    input wire logic [23:0] EVENT_COND,
    input wire logic SUPPLY_LOW_TRIP,
    input wire logic SUPPLY_HIGH_OK,
    input wire logic TEMP_RAW_VALID,
    input wire logic [23:0] TEMP_RAW,
    input wire logic PULSE_VALID,
    input wire logic [23:0] ACTIVE_ENERGY_PULSE_VALUE_IN,
    input wire logic [23:0] APPARENT_ENERGY_PULSE_VALUE_IN,
    input wire logic [23:0] REACTIVE_ENERGY_PULSE_VALUE_IN,
    output logic [23:0] DIE_TEMPERATURE,
    output logic [23:0] ENERGY_PULSE_A,
    output logic [23:0] ENERGY_PULSE_S,
    output logic [23:0] ENERGY_PULSE_Q,
    output logic INT_REQ
);
    msirq_state_t s_q;
    msirq_state_t s_d;
    msirq_apb_req_t req;
    logic [7:0] idx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic signed [48:0] prod;
    // One spare bit so a gain near four plus a full bias cannot wrap before saturation
    logic signed [26:0] scaled;
    logic [23:0] cond;
    logic [23:0] clr;

    function automatic logic mapped(input logic [7:0] i);
        mapped = (i == MSIRQ_IDX_FLAGS) || (i == MSIRQ_IDX_ENABLE) ||
                 (i == MSIRQ_IDX_TEMP) || (i == MSIRQ_IDX_ACTIVE_ENERGY_PULSE_VALUE) ||
                 (i == MSIRQ_IDX_APPARENT_ENERGY_PULSE_VALUE) || (i == MSIRQ_IDX_REACTIVE_ENERGY_PULSE_VALUE) ||
                 (i == MSIRQ_IDX_TSCALE) || (i == MSIRQ_IDX_TBIAS);
    endfunction : mapped

    always_comb begin
        req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
        idx = req.paddr[9:2];
        hit = mapped(idx) && (req.paddr[31:10] == 22'h000000) && (req.paddr[1:0] == 2'h0);
        wr_en = req.psel && req.penable && req.pwrite && hit;
        rd_en = req.psel && !req.penable && !req.pwrite;
    end

    // Temperature rescale: signed raw times unsigned gain plus bias
    always_comb begin
        prod = $signed(TEMP_RAW) * $signed({1'b0, s_q.tscale});
        scaled = 27'(prod >>> MSIRQ_TSCALE_FRAC) + 27'($signed(s_q.tbias));
    end

    always_comb begin
        s_d = s_q;
        s_d.ev_s1 = EVENT_COND;
        s_d.ev_s2 = s_q.ev_s1;
        s_d.ls_s1 = {SUPPLY_HIGH_OK, SUPPLY_LOW_TRIP};
        s_d.ls_s2 = s_q.ls_s1;
        cond = s_q.ev_s2;
        // Low supply latches on the low trip and only releases above the high level
        if (s_q.ls_s2[0]) begin
            s_d.ls_latched = 1'b1;
        end else if (s_q.ls_s2[1]) begin
            s_d.ls_latched = 1'b0;
        end
        cond[B_LOW_SUPPLY] = s_q.ls_latched || s_q.ls_s2[0];
        cond[B_TEMP_UPD] = s_q.ev_s2[B_TEMP_UPD] || TEMP_RAW_VALID;
        s_d.pslverr = 1'b0;
        clr = 24'h000000;
        if (wr_en && idx == MSIRQ_IDX_FLAGS) begin
            clr = req.pwdata[23:0];
        end
        for (int i = 1; i < MSIRQ_W; i++) begin
            // Set beats clear; a still-present condition keeps the bit
            s_d.flags[i] = cond[i] || (s_q.flags[i] && !clr[i]);
        end
        // Active low: a bad command drives zero, a one written restores it when gone
        s_d.flags[B_BAD_CMD_N] = !cond[B_BAD_CMD_N] &&
                                 (s_q.flags[B_BAD_CMD_N] || clr[B_BAD_CMD_N]);
        if (wr_en && idx == MSIRQ_IDX_ENABLE) begin
            s_d.enable = req.pwdata[23:0];
        end
        if (wr_en && idx == MSIRQ_IDX_TSCALE) begin
            s_d.tscale = req.pwdata[23:0];
        end
        if (wr_en && idx == MSIRQ_IDX_TBIAS) begin
            s_d.tbias = req.pwdata[23:0];
        end
        if (TEMP_RAW_VALID) begin
            // Saturate to the signed 24-bit range of 8.16 Celsius
            if (scaled > 27'sh07fffff) begin
                s_d.temp = 24'h7fffff;
            end else if (scaled < -27'sh0800000) begin
                s_d.temp = 24'h800000;
            end else begin
                s_d.temp = scaled[23:0];
            end
        end
        if (PULSE_VALID) begin
            s_d.active_energy_pulse_value = ACTIVE_ENERGY_PULSE_VALUE_IN;
            s_d.apparent_energy_pulse_value = APPARENT_ENERGY_PULSE_VALUE_IN;
            s_d.reactive_energy_pulse_value = REACTIVE_ENERGY_PULSE_VALUE_IN;
        end
        if (rd_en) begin
            case (idx)
                MSIRQ_IDX_FLAGS: s_d.prdata = {8'h00, s_q.flags};
                MSIRQ_IDX_ENABLE: s_d.prdata = {8'h00, s_q.enable};
                MSIRQ_IDX_TEMP: s_d.prdata = {8'h00, s_q.temp};
                MSIRQ_IDX_ACTIVE_ENERGY_PULSE_VALUE: s_d.prdata = {8'h00, s_q.active_energy_pulse_value};
                MSIRQ_IDX_APPARENT_ENERGY_PULSE_VALUE: s_d.prdata = {8'h00, s_q.apparent_energy_pulse_value};
                MSIRQ_IDX_REACTIVE_ENERGY_PULSE_VALUE: s_d.prdata = {8'h00, s_q.reactive_energy_pulse_value};
                MSIRQ_IDX_TSCALE: s_d.prdata = {8'h00, s_q.tscale};
                MSIRQ_IDX_TBIAS: s_d.prdata = {8'h00, s_q.tbias};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
        if (req.psel && !req.penable && !hit) begin
            s_d.pslverr = 1'b1;
        end
        // Bad-command event is the bit reading zero
        s_d.irq = (|(s_q.flags[23:1] & s_q.enable[23:1])) ||
                  (!s_q.flags[B_BAD_CMD_N] && s_q.enable[B_BAD_CMD_N]);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.flags <= MSIRQ_FLAGS_RST;
            s_q.enable <= MSIRQ_ENABLE_RST;
            s_q.tscale <= MSIRQ_TSCALE_RST;
            s_q.tbias <= MSIRQ_TBIAS_RST;
            s_q.ev_s1[B_BAD_CMD_N] <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Answer in the first access cycle; read data was captured in setup
    assign PREADY = 1'b1;
    assign PRDATA = s_q.prdata;
    assign PSLVERR = s_q.pslverr && PSEL && PENABLE;
    assign DIE_TEMPERATURE = s_q.temp;
    assign ENERGY_PULSE_A = s_q.active_energy_pulse_value;
    assign ENERGY_PULSE_S = s_q.apparent_energy_pulse_value;
    assign ENERGY_PULSE_Q = s_q.reactive_energy_pulse_value;
    assign INT_REQ = s_q.irq;
endmodule : msirq_top
`default_nettype wire

// >>> test/msirq_properties.sv
`default_nettype none
module msirq_properties (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PULSE_VALID,
    input wire logic [23:0] ACTIVE_ENERGY_PULSE_VALUE_IN,
    input wire logic [23:0] ENERGY_PULSE_A,
    input wire logic INT_REQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_acc;
        PSEL && PENABLE;
    endsequence
    a_ready_high: assert property (PREADY) else $error("pready low");
    a_reset_quiet: assert property ($rose(RESET_N) |-> !INT_REQ && PRDATA == 32'h0)
        else $error("not quiet");
    a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray err");
    a_flags_ok: assert property (s_acc ##0 (PADDR == 32'h3c) |-> !PSLVERR) else $error("err");
    a_bad_addr: assert property (s_acc ##0 (PADDR == 32'h40) |-> PSLVERR) else $error("no err");
    a_upper_zero: assert property (s_acc ##0 !PWRITE |-> PRDATA[31:24] == 8'h0)
        else $error("upper set");
    a_pulse_take: assert property (PULSE_VALID |=> ENERGY_PULSE_A == $past(ACTIVE_ENERGY_PULSE_VALUE_IN))
        else $error("pulse lost");
    a_pulse_hold: assert property (!PULSE_VALID |=> $stable(ENERGY_PULSE_A))
        else $error("pulse moved");
endmodule : msirq_properties
`default_nettype wire

// >>> test/msirq_src.sv
`default_nettype none
module msirq_src (
    input wire logic clk,
    input wire logic [25:0] want,
    output logic [25:0] lines = 26'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Conditions are levels that only the source drops; a flag outlives them until a one is written to clear it
    always @(posedge clk) begin
        lines <= want;
    end
endmodule : msirq_src
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb import msirq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] fla = 32'h3c, ena = 32'h68, tmp = 32'h6c;
    logic REF_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic tv = 1'b0, pv = 1'b0, PREADY, PSLVERR, irq, err;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd;
    logic [25:0] want = 26'h2000000, lines;
    logic [23:0] traw = 24'h0, pe = 24'h800001, m, fs, dt, pa, ps, pq;
    int err_count = 0, comparisons = 0, cyc = 0;
    always #2 REF_CLK = ~REF_CLK;
    msirq_src msirq_src_inst (.clk(REF_CLK), .want(want), .lines(lines));
    msirq_top msirq_top_inst (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_COND(lines[23:0]),
        .SUPPLY_LOW_TRIP(lines[24]), .SUPPLY_HIGH_OK(lines[25]), .TEMP_RAW_VALID(tv),
        .TEMP_RAW(traw), .PULSE_VALID(pv), .ACTIVE_ENERGY_PULSE_VALUE_IN(pe), .APPARENT_ENERGY_PULSE_VALUE_IN(~pe), .REACTIVE_ENERGY_PULSE_VALUE_IN(traw),
        .DIE_TEMPERATURE(dt), .ENERGY_PULSE_A(pa), .ENERGY_PULSE_S(ps), .ENERGY_PULSE_Q(pq),
        .INT_REQ(irq));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1) @(posedge REF_CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask : apb
    task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task automatic tpulse(input logic [23:0] r);
        traw <= r;
        tv <= 1'b1;
        @(posedge REF_CLK);
        tv <= 1'b0;
        repeat (4) @(posedge REF_CLK);
    endtask : tpulse
    task automatic tally_and_finish();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // The whole run needs well under half of this
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        rdc(fla, 32'h1, "flags");
        rdc(ena, 32'h0, "enable");
        for (int i = 0; i < 24; i++) begin
            // Low supply has its own latch and is exercised below
            if (i == 2) continue;
            m = 24'h1 << i;
            fs = (i == 0) ? 24'h0 : (m | 24'h1);
            want[23:0] <= m;
            repeat (6) @(posedge REF_CLK);
            chk("irq masked", 32'h0, {31'h0, irq});
            apb(1'b1, fla, {8'h0, m});
            rdc(fla, {8'h0, fs}, "flag kept");
            apb(1'b1, ena, {8'h0, m});
            repeat (2) @(posedge REF_CLK);
            chk("irq", 32'h1, {31'h0, irq});
            apb(1'b1, ena, 32'h0);
            want[23:0] <= 24'h0;
            repeat (6) @(posedge REF_CLK);
            // Condition is gone now, so only the zero written can keep the flag
            apb(1'b1, fla, {8'h0, ~m});
            rdc(fla, {8'h0, fs}, "zero write");
            apb(1'b1, fla, {8'h0, m});
            rdc(fla, 32'h1, "flag cleared");
        end
        want[25:24] <= 2'b01;
        repeat (6) @(posedge REF_CLK);
        want[25:24] <= 2'b00;
        repeat (6) @(posedge REF_CLK);
        apb(1'b1, fla, 32'h4);
        rdc(fla, 32'h5, "supply held");
        want[25:24] <= 2'b10;
        repeat (6) @(posedge REF_CLK);
        apb(1'b1, fla, 32'h4);
        rdc(fla, 32'h1, "supply cleared");
        tpulse(24'h0a8000);
        rdc(tmp, 32'h0a8000, "temp");
        rdc(fla, 32'h81, "temp flag");
        chk("temp pin", 32'h0a8000, {8'h0, dt});
        apb(1'b1, 32'h80, 32'h200000);
        apb(1'b1, 32'h84, 32'h010000);
        tpulse(24'h800000);
        rdc(tmp, 32'hc10000, "temp scaled");
        chk("scaled pin", 32'hc10000, {8'h0, dt});
        rdc(32'h80, 32'h200000, "scale");
        pe <= 24'h7fffff;
        pv <= 1'b1;
        @(posedge REF_CLK);
        pv <= 1'b0;
        rdc(32'h74, 32'h7fffff, "active");
        rdc(32'h78, 32'h800000, "apparent");
        rdc(32'h7c, 32'h800000, "reactive");
        chk("active pin", 32'h7fffff, {8'h0, pa});
        chk("apparent pin", 32'h800000, {8'h0, ps});
        chk("reactive pin", 32'h800000, {8'h0, pq});
        apb(1'b0, 32'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        tally_and_finish();
    end
endmodule : tb
bind msirq_top msirq_properties msirq_properties_inst (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PULSE_VALID(PULSE_VALID), .ACTIVE_ENERGY_PULSE_VALUE_IN(ACTIVE_ENERGY_PULSE_VALUE_IN),
    .ENERGY_PULSE_A(ENERGY_PULSE_A), .INT_REQ(INT_REQ));
`default_nettype wire
